// file: amd_pkg.sv
// Purpose: shared constants and types of the address map decoder
// Assumes: 24-bit physical space seen through a 32-bit cpu address
// Notes: all offsets are physical (upper cpu address bits dropped)
`default_nettype none
package amd_pkg;

  // access width requested by the cpu
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} amd_size_e;

  // target chosen for one access
  typedef enum logic [2:0] {RG_ROM, RG_RAM, RG_PERI, RG_MODE, RG_EXT, RG_PROHIB} amd_region_e;

  // physical space
  localparam int PHYS_AW = 24;
  localparam logic [23:0] ROM_LAST = 24'h0fffff;
  localparam logic [23:0] EXT_BASE = 24'h100000;
  localparam logic [23:0] EXT_LAST = 24'hff7fff;
  localparam logic [23:0] PROHIB_BASE = 24'hff8000;
  localparam logic [23:0] RAM_BASE = 24'hffb000;
  localparam logic [23:0] RAM_LAST = 24'hffefff;
  localparam logic [23:0] PERI_BASE = 24'hfff000;

  // on-chip controller hole inside the external area: nFF800..nFFFFF, n = 3, 7, b
  localparam logic [8:0] CTL_HOLE_MID = 9'h1ff;
  localparam logic [3:0] CTL_HOLE_N0 = 4'h3;
  localparam logic [3:0] CTL_HOLE_N1 = 4'h7;
  localparam logic [3:0] CTL_HOLE_N2 = 4'hb;

  // port widths
  localparam int RAM_AW = 14;
  localparam int ROM_AW = 20;
  localparam int PERI_AW = 10;
  localparam int EXT_AW = 22;

  // memory expansion mode register: offset in the 1 KB peripheral copy
  localparam logic [9:0] MODE_OFS = 10'h04c;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WR_MASK = 8'h0f;
  localparam int MODE_SIZE_LSB = 0;
  localparam int MODE_EXP_BIT = 2;
  localparam int MODE_WAIT_BIT = 3;

  // external size codes
  localparam logic [1:0] EXT_SZ_64K = 2'h0;
  localparam logic [1:0] EXT_SZ_256K = 2'h1;
  localparam logic [1:0] EXT_SZ_1M = 2'h2;
  localparam logic [1:0] EXT_SZ_4M = 2'h3;
  localparam logic [21:0] EXT_MASK_64K = 22'h00ffff;
  localparam logic [21:0] EXT_MASK_256K = 22'h03ffff;
  localparam logic [21:0] EXT_MASK_1M = 22'h0fffff;
  localparam logic [21:0] EXT_MASK_4M = 22'h3fffff;

  // read value for prohibited space and undefined lanes
  localparam logic [31:0] UNDEF_DATA = 32'h0000_0000;

endpackage
`default_nettype wire

// file: amd_region_dec.sv
// Purpose: classify a 24-bit physical address into its target region
// Assumes: purely combinational, driven from registered request state
// Notes: internal areas are tested first so they always win
`default_nettype none
module amd_region_dec (
  // address under test
  input wire logic [23:0] phys_addr,
  // expansion state
  input wire logic exp_active,
  // result
  output amd_pkg::amd_region_e region
);
  import amd_pkg::*;

  logic in_hole;

  // controller hole in the external area
  assign in_hole = (phys_addr[19:11] == CTL_HOLE_MID) &&
                   (phys_addr[23:20] == CTL_HOLE_N0 || phys_addr[23:20] == CTL_HOLE_N1 ||
                    phys_addr[23:20] == CTL_HOLE_N2);

  // priority decode, internal resources first
  always_comb begin
    if (phys_addr >= PERI_BASE) begin
      // image of the 1 KB copy: upper offset bits ignored, bit 0 ignored
      if (phys_addr[9:1] == MODE_OFS[9:1]) begin
        region = RG_MODE;
      end else begin
        region = RG_PERI;
      end
    end else if (phys_addr >= RAM_BASE && phys_addr <= RAM_LAST) begin
      region = RG_RAM;
    end else if (phys_addr >= PROHIB_BASE) begin
      region = RG_PROHIB;
    end else if (phys_addr <= ROM_LAST) begin
      region = RG_ROM;
    end else if (phys_addr >= EXT_BASE && phys_addr <= EXT_LAST && exp_active && !in_hole) begin
      region = RG_EXT;
    end else begin
      region = RG_PROHIB;
    end
  end

endmodule
`default_nettype wire

// file: amd_mode_reg.sv
// Purpose: memory expansion mode register and the pin functions it selects
// Assumes: written one byte at a time; single-bit ops arrive as byte rmw
// Notes: reset leaves every bus pin in port mode
`default_nettype none
module amd_mode_reg (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register access
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // decoded state
  output logic exp_active,
  output logic [1:0] ext_size,
  // pin function selects
  output logic port4_bus_en,
  output logic port5_bus_en,
  output logic port6_bus_en,
  output logic port9_bus_en,
  output logic port9_wait_en
);
  import amd_pkg::*;

  logic [7:0] memory_expansion_mode_reg_r;

  // software write, upper nibble held at zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      memory_expansion_mode_reg_r <= MODE_RESET;
    end else if (wr_en) begin
      memory_expansion_mode_reg_r <= wr_data & MODE_WR_MASK;
    end
  end

  // decoded fields
  assign rd_data = memory_expansion_mode_reg_r;
  assign exp_active = memory_expansion_mode_reg_r[MODE_EXP_BIT];
  assign ext_size = memory_expansion_mode_reg_r[MODE_SIZE_LSB +: 2];

  // pin functions: ports 4, 5, 9 carry the bus; port 6 carries high address lines
  assign port4_bus_en = exp_active;
  assign port5_bus_en = exp_active;
  assign port6_bus_en = exp_active && (ext_size != EXT_SZ_64K);
  assign port9_bus_en = exp_active;
  assign port9_wait_en = exp_active && memory_expansion_mode_reg_r[MODE_WAIT_BIT];

endmodule
`default_nettype wire

// file: amd_decoder.sv
// Purpose: route cpu accesses to rom, ram, peripherals or external bus
// Assumes: targets answer with a one-cycle ack on clk_sys
// Notes: one access in flight; peripheral word access takes two halfword steps
`default_nettype none
module amd_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // cpu request
  input wire logic cpu_req,
  input wire logic cpu_fetch,
  input wire logic cpu_we,
  input wire amd_pkg::amd_size_e cpu_size,
  input wire logic [31:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  // cpu answer
  output logic cpu_ready,
  output logic cpu_ack,
  output logic cpu_fault,
  output logic [31:0] cpu_rdata,
  // internal rom
  output logic rom_req,
  output logic [amd_pkg::ROM_AW-1:0] rom_addr,
  input wire logic rom_ack,
  input wire logic [31:0] rom_rdata,
  // internal ram
  output logic ram_req,
  output logic ram_we,
  output logic [3:0] ram_be,
  output logic [amd_pkg::RAM_AW-1:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic ram_ack,
  input wire logic [31:0] ram_rdata,
  // peripheral registers, halfword bus
  output logic per_req,
  output logic per_we,
  output logic per_byte_acc,
  output logic [amd_pkg::PERI_AW-1:0] per_addr,
  output logic [15:0] per_wdata,
  input wire logic per_ack,
  input wire logic per_byte_wide,
  input wire logic [15:0] per_rdata,
  // external memory bus
  output logic ext_req,
  output logic ext_we,
  output logic [3:0] ext_be,
  output logic [amd_pkg::EXT_AW-1:0] ext_addr,
  output logic [31:0] ext_wdata,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  // pin function selects
  output logic port4_bus_en,
  output logic port5_bus_en,
  output logic port6_bus_en,
  output logic port9_bus_en,
  output logic port9_wait_en
);
  import amd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LO, ST_HI, ST_DONE} amd_state_e;

  amd_state_e state_r;
  amd_state_e state_nxt;
  logic [23:0] addr_r;
  logic we_r;
  logic fetch_r;
  amd_size_e size_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic fault_r;
  amd_region_e region;
  logic exp_active;
  logic [1:0] ext_size;
  logic [7:0] mode_rd;
  logic mode_wr;
  logic step_done;
  logic blocked;
  logic per_word;

  // byte enables from size and low address bits
  function automatic logic [3:0] lane_be(input amd_size_e sz, input logic [1:0] a);
    logic [3:0] be;
    be = 4'h0;
    case (sz)
      SZ_BYTE: be = 4'h1 << a;
      SZ_HALF: be = a[1] ? 4'hc : 4'h3;
      SZ_WORD: be = 4'hf;
      default: be = 4'h0;
    endcase
    return be;
  endfunction

  // move the addressed lanes of a 32-bit read down to bit 0
  function automatic logic [31:0] lane_align(input amd_size_e sz, input logic [1:0] a,
                                             input logic [31:0] d);
    logic [31:0] sh;
    sh = d >> {a, 3'h0};
    case (sz)
      SZ_BYTE: lane_align = {24'h0, sh[7:0]};
      SZ_HALF: lane_align = {16'h0, sh[15:0]};
      default: lane_align = d;
    endcase
  endfunction

  // replicate narrow write data onto every lane
  function automatic logic [31:0] lane_spread(input amd_size_e sz, input logic [31:0] d);
    case (sz)
      SZ_BYTE: lane_spread = {4{d[7:0]}};
      SZ_HALF: lane_spread = {2{d[15:0]}};
      default: lane_spread = d;
    endcase
  endfunction

  // external image mask for the selected physical size
  function automatic logic [21:0] ext_mask(input logic [1:0] code);
    case (code)
      EXT_SZ_64K: ext_mask = EXT_MASK_64K;
      EXT_SZ_256K: ext_mask = EXT_MASK_256K;
      EXT_SZ_1M: ext_mask = EXT_MASK_1M;
      default: ext_mask = EXT_MASK_4M;
    endcase
  endfunction

  // region of the request in flight
  amd_region_dec u_region (
    .phys_addr(addr_r),
    .exp_active(exp_active),
    .region(region)
  );

  // expansion mode register and pin functions
  amd_mode_reg u_mode (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wr_en(mode_wr),
    .wr_data(wdata_r[7:0]),
    .rd_data(mode_rd),
    .exp_active(exp_active),
    .ext_size(ext_size),
    .port4_bus_en(port4_bus_en),
    .port5_bus_en(port5_bus_en),
    .port6_bus_en(port6_bus_en),
    .port9_bus_en(port9_bus_en),
    .port9_wait_en(port9_wait_en)
  );

  // fetch into the peripheral area is refused without touching anything
  assign blocked = fetch_r && (region == RG_PERI || region == RG_MODE);
  assign per_word = (size_r == SZ_WORD);

  // capture a request; data accesses and fetches both drop bits 31..24
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_r <= 24'h000000;
      we_r <= 1'b0;
      fetch_r <= 1'b0;
      size_r <= SZ_BYTE;
      wdata_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && cpu_req) begin
      addr_r <= cpu_addr[PHYS_AW-1:0];
      we_r <= cpu_we && !cpu_fetch;
      fetch_r <= cpu_fetch;
      size_r <= cpu_size;
      wdata_r <= cpu_wdata;
    end
  end

  // completion of the current step
  always_comb begin
    step_done = 1'b0;
    if (state_r == ST_LO || state_r == ST_HI) begin
      if (blocked) begin
        step_done = 1'b1;
      end else begin
        case (region)
          RG_ROM: step_done = rom_ack;
          RG_RAM: step_done = ram_ack;
          RG_PERI: step_done = per_ack;
          RG_EXT: step_done = ext_ack;
          default: step_done = 1'b1; // mode register and prohibited finish at once
        endcase
      end
    end
  end

  // sequencer: peripheral word accesses run a second halfword step
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (cpu_req) state_nxt = ST_LO;
      ST_LO: begin
        if (step_done) begin
          state_nxt = (region == RG_PERI && per_word && !blocked) ? ST_HI : ST_DONE;
        end
      end
      ST_HI: if (step_done) state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // read data collection
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && cpu_req) begin
      rdata_r <= UNDEF_DATA;
    end else if (step_done && !blocked) begin
      case (region)
        RG_ROM: rdata_r <= lane_align(size_r, addr_r[1:0], rom_rdata);
        RG_RAM: rdata_r <= lane_align(size_r, addr_r[1:0], ram_rdata);
        RG_EXT: rdata_r <= lane_align(size_r, addr_r[1:0], ext_rdata);
        RG_MODE: rdata_r <= {24'h0, mode_rd};
        RG_PERI: begin
          if (state_r == ST_HI) begin
            rdata_r[31:16] <= per_rdata;
          end else if (size_r == SZ_BYTE || per_byte_wide) begin
            rdata_r <= {24'h0, per_rdata[7:0]};
          end else begin
            rdata_r[15:0] <= per_rdata;
          end
        end
        default: rdata_r <= UNDEF_DATA;
      endcase
    end
  end

  // fault flag for refused fetches
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_r <= 1'b0;
    end else if (state_r == ST_LO) begin
      fault_r <= blocked;
    end
  end

  // mode register write, prohibited writes store nothing
  assign mode_wr = (state_r == ST_LO) && (region == RG_MODE) && we_r && !blocked;

  // cpu side
  assign cpu_ready = (state_r == ST_IDLE);
  assign cpu_ack = (state_r == ST_DONE);
  assign cpu_fault = fault_r;
  assign cpu_rdata = rdata_r;

  // internal rom
  assign rom_req = (state_r == ST_LO) && (region == RG_ROM) && !blocked;
  assign rom_addr = addr_r[ROM_AW-1:0];

  // internal ram, offset from its base
  assign ram_req = (state_r == ST_LO) && (region == RG_RAM);
  assign ram_we = we_r;
  assign ram_be = lane_be(size_r, addr_r[1:0]);
  assign ram_addr = RAM_AW'(addr_r - RAM_BASE);
  assign ram_wdata = lane_spread(size_r, wdata_r);

  // peripheral halfword bus: bit 0 dropped, second step at n+2
  assign per_req = (state_r == ST_LO || state_r == ST_HI) && (region == RG_PERI) && !blocked;
  assign per_we = we_r;
  assign per_byte_acc = (size_r == SZ_BYTE);
  assign per_addr = {addr_r[PERI_AW-1:2], (state_r == ST_HI) | addr_r[1], 1'b0};

  // write lanes: byte data sits low; byte-wide registers take only the low byte, except in the second word step
  always_comb begin
    if (state_r == ST_HI) begin
      per_wdata = wdata_r[31:16];
    end else if (size_r == SZ_BYTE || per_byte_wide) begin
      per_wdata = {8'h00, wdata_r[7:0]};
    end else begin
      per_wdata = wdata_r[15:0];
    end
  end

  // external bus only for the external region, imaged onto the physical size
  assign ext_req = (state_r == ST_LO) && (region == RG_EXT);
  assign ext_we = we_r;
  assign ext_be = lane_be(size_r, addr_r[1:0]);
  assign ext_addr = addr_r[EXT_AW-1:0] & ext_mask(ext_size);
  assign ext_wdata = lane_spread(size_r, wdata_r);

endmodule
`default_nettype wire

// file: amd_decoder_properties.sv
// Purpose: concurrent checks on the address map decoder ports
// Assumes: one clock domain, active-low asynchronous reset
// Notes: bound to the decoder from the testbench top file
`default_nettype none
module amd_decoder_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // cpu side
  input wire logic cpu_req,
  input wire logic cpu_fetch,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_ready,
  input wire logic cpu_ack,
  input wire logic cpu_fault,
  // target requests
  input wire logic rom_req,
  input wire logic ram_req,
  input wire logic per_req,
  input wire logic [9:0] per_addr,
  input wire logic ext_req,
  // pin selects
  input wire logic port4_bus_en,
  input wire logic port5_bus_en,
  input wire logic port6_bus_en,
  input wire logic port9_bus_en,
  input wire logic port9_wait_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic take, peri;
  // a request is taken while idle; the peripheral area is the top 4 kb
  assign take = cpu_req && cpu_ready;
  assign peri = cpu_addr[23:12] == 12'hfff;
  a_fetch_refused: assert property (take && cpu_fetch && peri |=> !per_req ##1 cpu_ack && cpu_fault)
    else $error("peripheral fetch not refused");
  a_peri_route: assert property (take && !cpu_fetch && peri && cpu_addr[9:1] != 9'h026
    |=> per_req && per_addr == {$past(cpu_addr[9:1]), 1'b0})
    else $error("peripheral step address wrong");
  a_internal_local: assert property ((ram_req || per_req) |-> !ext_req)
    else $error("internal access reached external bus");
  a_ext_expansion: assert property (ext_req |-> port4_bus_en)
    else $error("external cycle in single-chip mode");
  a_rom_fetch: assert property (take && cpu_fetch && cpu_addr[23:20] == 4'h0 |=> rom_req)
    else $error("fetch image not routed to rom");
  a_ram_window: assert property (take && cpu_addr[23:12] inside {[12'hffb:12'hffe]} |=> ram_req && !ext_req)
    else $error("ram window not routed to ram");
  a_prohib_quiet: assert property (take && cpu_addr[23:12] inside {[12'hff8:12'hffa]}
    |=> !(rom_req || ram_req || per_req || ext_req) ##1 cpu_ack)
    else $error("prohibited access reached a target");
  a_pin_group: assert property (port6_bus_en || port9_wait_en |-> port4_bus_en && port5_bus_en && port9_bus_en)
    else $error("pin selects inconsistent");
  a_reset_single: assert property ($rose(nrst) |-> !port4_bus_en && !port6_bus_en && !port9_wait_en)
    else $error("bus pins selected after reset");
endmodule
`default_nettype wire

// file: amd_tgt_model.sv
// Purpose: behavioural target answering one decoder request port
// Assumes: request stays high until its acknowledge cycle
// Notes: unwritten words read zero; the idle data bus toggles every cycle
`default_nettype none
module amd_tgt_model #(parameter int AW = 22, parameter int DW = 32) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request
  input wire logic req,
  input wire logic we,
  input wire logic [DW/8-1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic [3:0] wt,
  // answer
  output logic ack,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [int];
  logic [3:0] cnt_r;
  int idx;
  always_comb idx = int'(addr) / (DW / 8);
  // answer after wt wait cycles; data only valid with the one-cycle ack
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      cnt_r <= 4'h0;
      rdata <= '0;
    end else if (req && !ack && cnt_r == wt) begin
      ack <= 1'b1;
      cnt_r <= 4'h0;
      rdata <= mem.exists(idx) ? mem[idx] : '0;
    end else begin
      ack <= 1'b0;
      cnt_r <= (req && !ack) ? cnt_r + 4'h1 : 4'h0;
      rdata <= ~rdata;  // released bus never shows the old value
      if (ack && req && we) begin
        if (!mem.exists(idx)) mem[idx] = '0;
        for (int b = 0; b < DW / 8; b++) if (be[b]) mem[idx][8 * b +: 8] = wdata[8 * b +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the address map decoder
// Assumes: targets are behavioural models sharing one random wait count
// Notes: expected data kept in a byte shadow keyed by target and offset
`default_nettype none
module tb;
  import amd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CMP(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk_sys = 1'b0, nrst = 1'b1, cpu_req = 1'b0, cpu_fetch = 1'b0, cpu_we = 1'b0;
  amd_size_e cpu_size = SZ_BYTE;
  logic [31:0] cpu_addr = '0, cpu_wdata = '0, cpu_rdata, rom_rdata, ram_wdata, ram_rdata, ext_wdata, ext_rdata, a;
  logic cpu_ready, cpu_ack, cpu_fault, rom_req, rom_ack, ram_req, ram_we, ram_ack, per_req, per_we, per_ack;
  logic per_byte_acc, per_byte_wide, ext_req, ext_we, ext_ack;
  logic port4_bus_en, port5_bus_en, port6_bus_en, port9_bus_en, port9_wait_en;
  logic [3:0] ram_be, ext_be, wt = 4'h0;
  logic [19:0] rom_addr;
  logic [13:0] ram_addr;
  logic [9:0] per_addr;
  logic [15:0] per_wdata, per_rdata;
  logic [21:0] ext_addr;
  logic [7:0] mode = 8'h00;
  logic [7:0] sh [int];
  logic [31:0] r;
  logic f;
  int failures = 0, checks = 0;
  // clock and the byte-wide register area of the peripheral copy
  always #5 clk_sys = ~clk_sys;
  assign per_byte_wide = per_addr < 10'h040;
  amd_decoder dut (.clk_sys, .nrst, .cpu_req, .cpu_fetch, .cpu_we, .cpu_size, .cpu_addr, .cpu_wdata, .cpu_ready,
    .cpu_ack, .cpu_fault, .cpu_rdata, .rom_req, .rom_addr, .rom_ack, .rom_rdata, .ram_req, .ram_we, .ram_be,
    .ram_addr, .ram_wdata, .ram_ack, .ram_rdata, .per_req, .per_we, .per_byte_acc, .per_addr, .per_wdata, .per_ack,
    .per_byte_wide, .per_rdata, .ext_req, .ext_we, .ext_be, .ext_addr, .ext_wdata, .ext_ack, .ext_rdata,
    .port4_bus_en, .port5_bus_en, .port6_bus_en, .port9_bus_en, .port9_wait_en);
  // rom is read-only: its write lanes follow the ram bus but are never stored
  amd_tgt_model #(.AW(20)) u_rom (.clk_sys, .nrst, .req(rom_req), .we(1'b0), .be(ram_be), .addr(rom_addr),
    .wdata(ram_wdata), .wt, .ack(rom_ack), .rdata(rom_rdata));
  amd_tgt_model #(.AW(14)) u_ram (.clk_sys, .nrst, .req(ram_req), .we(ram_we), .be(ram_be),
    .addr(ram_addr), .wdata(ram_wdata), .wt, .ack(ram_ack), .rdata(ram_rdata));
  amd_tgt_model #(.AW(10), .DW(16)) u_per (.clk_sys, .nrst, .req(per_req), .we(per_we),
    .be(per_byte_acc ? 2'b01 : 2'b11), .addr(per_addr), .wdata(per_wdata), .wt, .ack(per_ack), .rdata(per_rdata));
  amd_tgt_model u_ext (.clk_sys, .nrst, .req(ext_req), .we(ext_we), .be(ext_be),
    .addr(ext_addr), .wdata(ext_wdata), .wt, .ack(ext_ack), .rdata(ext_rdata));

  // storage key of an address: target in the top byte, -1 where nothing is stored
  function automatic int key(input logic [31:0] ad);
    logic [23:0] p;
    p = ad[23:0];
    if (p inside {[24'hffb000:24'hffefff]}) return 32'h100_0000 + int'(p - 24'hffb000);
    if (p >= 24'hfff000) return 32'h200_0000 + int'(p[9:0] & 10'h3fe);
    if (mode[2] && p inside {[24'h100000:24'hff7fff]} && !(p[19:11] == 9'h1ff && p[23:20] inside {4'h3, 4'h7, 4'hb}))
      return 32'h300_0000 + int'(p & ((24'h1_0000 << (2 * mode[1:0])) - 24'h1));
    return -1;
  endfunction

  task automatic summarize;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one cpu access: hold the request until taken, then wait for the ack
  task automatic acc(input logic fe, w, input amd_size_e s, input logic [31:0] ad, d);
    int n;
    cpu_req <= 1'b1;
    cpu_fetch <= fe;
    cpu_we <= w;
    cpu_size <= s;
    cpu_addr <= ad;
    cpu_wdata <= d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (cpu_ready !== 1'b1 && n < 40);
    cpu_req <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (cpu_ack !== 1'b1 && n < 40);
    if (n >= 40) begin failures++; summarize(); end
    r = cpu_rdata;
    f = cpu_fault;
  endtask

  // data access checked against the shadow and the mode register copy
  task automatic op(input logic w, input amd_size_e s, input logic [31:0] ad, d);
    logic [31:0] e;
    int k;
    k = key(ad);
    e = '0;
    if (ad[23:12] == 12'hfff && ad[9:1] == 9'h026) begin
      if (w) mode = d[7:0] & 8'h0f;
      e = {24'h0, mode};
    end else if (k >= 0) begin
      for (int i = 0; i < (1 << s); i++) begin
        if (k / 32'h100_0000 == 2 && (k + i) % 2 == 1 && ((k + i) & 32'h3ff) < 32'h40) continue;
        if (w) sh[k + i] = d[8 * i +: 8];
        else if (sh.exists(k + i)) e[8 * i +: 8] = sh[k + i];
      end
    end
    wt <= 4'($urandom_range(3));
    acc(1'b0, w, s, ad, d);
    if (!w) `CMP(r, e)
    `CMP(f, 1'b0)
    `CMP({port4_bus_en, port5_bus_en, port6_bus_en, port9_bus_en, port9_wait_en}, {mode[2], mode[2],
      mode[2] && mode[1:0] != 2'h0, mode[2], mode[2] && mode[3]})
  endtask

  initial begin
    amd_size_e s;
    void'($urandom(42));
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    op(1'b1, SZ_WORD, 32'h0020_0000, 32'h1234_5678);
    op(1'b0, SZ_WORD, 32'h0020_0000, 32'h0);
    // ram through random images, all widths
    for (int i = 0; i < 12; i++) begin
      s = amd_size_e'(i % 3);
      a = {8'($urandom), 24'hffb000 + 24'($urandom_range(16'h3fff))} & ~((32'h1 << s) - 32'h1);
      op(1'b1, s, a, $urandom);
      op(1'b0, s, {~a[31:24], a[23:0]}, 32'h0);
    end
    op(1'b1, SZ_WORD, 32'hffff_9000, $urandom);
    op(1'b0, SZ_WORD, 32'hffff_9000, 32'h0);
    // peripheral copy, images, odd bytes, byte-wide and split word accesses (defined offsets only)
    op(1'b1, SZ_HALF, 32'hffff_f100, $urandom);
    op(1'b0, SZ_HALF, 32'hffff_f500, 32'h0);
    op(1'b0, SZ_BYTE, 32'hffff_f101, 32'h0);
    op(1'b1, SZ_HALF, 32'hffff_f010, $urandom);
    op(1'b0, SZ_HALF, 32'hffff_f010, 32'h0);
    op(1'b1, SZ_WORD, 32'hffff_f060, $urandom);
    op(1'b0, SZ_WORD, 32'hffff_f060, 32'h0);
    op(1'b1, SZ_WORD, 32'hffff_f120, $urandom);
    op(1'b0, SZ_HALF, 32'hffff_f122, 32'h0);
    acc(1'b1, 1'b0, SZ_WORD, 32'hffff_f000, 32'h0);
    `CMP({f, r}, 33'h1_0000_0000)
    acc(1'b1, 1'b0, SZ_WORD, {8'($urandom), 24'h000100}, 32'h0);
    `CMP(f, 1'b0)
    op(1'b1, SZ_BYTE, 32'hffff_f04c, 32'hff);
    op(1'b0, SZ_BYTE, 32'hffff_f44d, 32'h0);
    // every external size, then a read through the next image
    for (int z = 0; z < 4; z++) begin
      op(1'b1, SZ_BYTE, 32'hffff_f04c, 32'h4 | z);
      a = 32'h0010_0000 + (($urandom % 32'h40_0000) & ~32'h3);
      op(1'b1, SZ_WORD, a, $urandom);
      op(1'b0, SZ_WORD, a + (32'h1_0000 << (2 * z)), 32'h0);
      op(1'b0, SZ_HALF, 32'h00ff_e000, 32'h0);
    end
    op(1'b1, SZ_WORD, 32'h003f_f800, 32'h5a5a_5a5a);
    op(1'b0, SZ_WORD, 32'h003f_f800, 32'h0);
    // reset in mid-run with expansion on: mode register and pins back to single-chip
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    mode = 8'h00;
    @(posedge clk_sys);
    op(1'b0, SZ_BYTE, 32'hffff_f04c, 32'h0);
    summarize();
  end
endmodule
bind amd_decoder amd_decoder_properties u_props (.clk_sys, .nrst, .cpu_req, .cpu_fetch, .cpu_addr, .cpu_ready,
  .cpu_ack, .cpu_fault, .rom_req, .ram_req, .per_req, .per_addr, .ext_req, .port4_bus_en, .port5_bus_en,
  .port6_bus_en, .port9_bus_en, .port9_wait_en);
`default_nettype wire
